// File: common/ssq_pkg.sv
// package of constants and types for the stored pattern sequencer
package ssq_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_EXPO    = 8'h08;
  localparam logic [7:0] OFS_PERIOD  = 8'h0C;
  localparam logic [7:0] OFS_DELAY   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_GEN_TAB = 8'h80; // 32 words up to 0xFC
  // control fields
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_ONCE = 1;
  localparam int CTRL_NEXT = 2;
  // configuration fields
  localparam int CFG_DEPTH_LSB = 0;  // 4 bits
  localparam int CFG_COUNT_LSB = 8;  // 7 bits
  localparam int CFG_TYPE_LSB  = 16; // 2 bits
  localparam int CFG_TRIG_LSB  = 20; // 2 bits
  localparam int CFG_LED_LSB   = 24; // 2 bits
  // generator table entry fields
  localparam int GEN_NUM_LSB = 0; // 4 bits
  localparam int GEN_INV_BIT = 4;
  // limits
  localparam logic [3:0]  DEPTH_MIN   = 4'h1;
  localparam logic [3:0]  DEPTH_MAX   = 4'h8;
  localparam logic [10:0] BIT_PLANES  = 11'd96;
  localparam logic [6:0]  GEN_ENTRIES = 7'd32;
  // values after reset, and minimum exposure and period
  localparam logic [3:0]  RST_DEPTH  = 4'h1;
  localparam logic [6:0]  RST_COUNT  = 7'h01;
  localparam logic [23:0] RST_EXPO   = 24'd8000;
  localparam logic [23:0] RST_PERIOD = 24'd8333;
  localparam logic [23:0] RST_DELAY  = 24'd0;
  localparam logic [23:0] MIN_EXPO   = 24'd250;
  localparam logic [23:0] MIN_PERIOD = 24'd250;
  // microsecond tick derived from the clock rate
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS         = 1000;
  localparam logic [7:0] US_CYCLES = 8'(US_NS / CLK_PERIOD_NS);
  // modes
  typedef enum logic [1:0] {
    TYP_NORMAL = 2'b00, TYP_INVERT = 2'b01, TYP_GEN = 2'b10
  } ssq_type_t;
  typedef enum logic [1:0] {
    TRG_AUTO = 2'b00, TRG_CMD = 2'b01, TRG_EXT_POS = 2'b10, TRG_EXT_NEG = 2'b11
  } ssq_trig_t;
  typedef enum logic [1:0] {
    LED_RED = 2'b00, LED_GREEN = 2'b01, LED_BLUE = 2'b10
  } ssq_led_sel_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT = 3'b001, ST_DELAY = 3'b010, ST_SHOW = 3'b011,
    ST_DARK = 3'b100
  } ssq_state_t;
  // light source drive
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } ssq_led_t;
  // what the display path shows
  typedef struct packed {
    logic [6:0] index;   // stored pattern number
    logic       invert;  // show complement
    logic       gen_en;  // take generator instead of store
    logic [3:0] gen_num; // generator pattern number
  } ssq_pat_t;
endpackage

// File: tb/ssq_trig_src.sv
// external trigger source model driving the trigger pin
`timescale 1ns/10ps
`default_nettype none
module ssq_trig_src (
  input  wire logic i_clk,
  output logic      o_trig
);
  // pin rests low until a polarity is chosen
  initial o_trig = 1'b0;
  // one asserting pulse, then back to the inactive level
  task automatic fire(input logic pol, input int width);
    @(posedge i_clk) o_trig <= pol;
    repeat (width) @(posedge i_clk);
    o_trig <= ~pol;
  endtask
  // settle the pin at the inactive level of a polarity
  task automatic park(input logic pol);
    @(posedge i_clk) o_trig <= ~pol;
  endtask
endmodule // ssq_trig_src
`default_nettype wire

// File: tb/tb_stored_pattern_sequencer.sv
// self-checking bench for the stored pattern sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_stored_pattern_sequencer;
  import ssq_pkg::*;
  logic        clk, rst, psel, pen, pwr, ext, pready, pslverr, show;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  ssq_led_t    led;
  ssq_pat_t    pat, last_pat;
  logic [33:0] bus_q[$];
  logic [15:0] pat_q[$];
  logic [33:0] b;
  logic [15:0] p, seen;
  logic [31:0] rnd;
  int          fails, total_checks, pops, quiet;

  ssq_sequencer DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EXT_TRIG(ext), .O_LED(led),
    .O_SHOW(show), .O_PAT(pat));
  ssq_trig_src src (.i_clk(clk), .o_trig(ext));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare one value and count it
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // xorshift step for random table entries
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // apb transfer; notes the expected response before driving
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] rexp);
    int n;
    bus_q.push_back({~wr, err, rexp});
    @(posedge clk);
    psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // note an expected shown pattern {led, index, invert, gen_en, gen_num}
  task automatic want(input logic [2:0] l, input logic [6:0] i, input logic v,
                      input logic g, input logic [3:0] n);
    pat_q.push_back({l, i, v, g, n});
  endtask

  // wait until n patterns have been seen in total
  task automatic wait_pops(input int n);
    int k;
    k = 0;
    while (pops < n && k < 100000) begin
      @(posedge clk);
      k++;
    end
    if (pops < n) begin
      fails++;
      conclude();
    end
  endtask

  // bus monitor: compare each completed transfer with the oldest note
  always @(posedge clk) begin
    if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1) begin
      if (bus_q.size() == 0) check("bus_extra", 0, 1);
      else begin
        b = bus_q.pop_front();
        check("pslverr", b[32], pslverr);
        if (b[33]) check("prdata", b[31:0], prdata);
      end
    end
  end

  // display monitor: a new pattern shows on a rise after at least four dark cycles or a change while shown
  always @(posedge clk) begin
    if (show === 1'b1 && (pat !== last_pat || quiet >= 4)) begin
      last_pat = pat;
      pops++;
      if (pat_q.size() == 0) check("show_extra", 0, 1);
      else begin
        p = pat_q.pop_front();
        seen = {led, pat};
        if (p[4] !== 1'b1) seen[3:0] = 4'h0; // number matters in generator type only
        check("pattern", p, seen);
      end
    end
    quiet = (show === 1'b1) ? 0 : ((quiet < 8) ? quiet + 1 : quiet);
  end

  // main sequence
  initial begin
    int t;
    logic [4:0] e[3];
    logic [31:0] bad[8];
    bad = '{32'h0000_0100, 32'h0000_0109, 32'h0000_0001, 32'h0000_0D08,
            32'h0001_0102, 32'h0002_2101, 32'h0003_0101, 32'h0300_0101};
    fails = 0; total_checks = 0; pops = 0; quiet = 8; last_pat = '0;
    rnd = 32'd80948;
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped and read-only places, refused settings
    apb(0, OFS_CFG, 0, 0, 32'h0000_0101);
    apb(0, OFS_EXPO, 0, 0, 32'h0000_1F40);
    apb(0, OFS_PERIOD, 0, 0, 32'h0000_208D);
    apb(0, 8'h20, 0, 1, 32'h0000_0000);
    apb(0, 8'h81, 0, 1, 32'h0000_0000);
    apb(1, OFS_STATUS, 32'h0000_0001, 1, 0);
    apb(1, OFS_CFG, 32'h0000_6001, 0, 0);
    apb(1, OFS_CFG, 32'h0000_0C08, 0, 0);
    for (int i = 0; i < 8; i++) apb(1, OFS_CFG, bad[i], 1, 0);
    apb(0, OFS_CFG, 0, 0, 32'h0000_0C08);
    // command trigger, normal type, depth two, green, wrap after three
    apb(1, OFS_CFG, 32'h0110_0302, 0, 0);
    apb(1, OFS_CTRL, 32'h0000_0001, 0, 0);
    repeat (20) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      want(3'b010, 7'(k % 3), 0, 0, 0);
      apb(1, OFS_CTRL, 32'h0000_0005, 0, 0);
      wait_pops(k + 1);
    end
    apb(1, OFS_CTRL, 32'h0000_0000, 0, 0);
    // inverse interleaved, positive external trigger
    apb(1, OFS_CFG, 32'h0021_0201, 0, 0);
    apb(1, OFS_CTRL, 32'h0000_0001, 0, 0);
    for (int k = 0; k < 5; k++) begin
      want(3'b100, 7'((k / 2) % 2), k[0], 0, 0);
      src.fire(1'b1, 4);
      wait_pops(5 + k);
    end
    apb(1, OFS_CTRL, 32'h0000_0000, 0, 0);
    // generator type, negative external trigger, blue, single pass
    src.park(1'b0);
    apb(1, OFS_CFG, 32'h0232_0301, 0, 0);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      e[i] = rnd[4:0];
      apb(1, 8'(OFS_GEN_TAB + 4 * i), {27'h0, e[i]}, 0, 0);
    end
    apb(1, 8'hFC, 32'h0000_001F, 0, 0);
    apb(0, 8'hFC, 0, 0, 32'h0000_001F);
    apb(0, 8'h84, 0, 0, {27'h0, e[1]});
    apb(1, OFS_CTRL, 32'h0000_0003, 0, 0);
    for (int k = 0; k < 3; k++) begin
      want(3'b001, 7'(k), e[k][4], 1, e[k][3:0]);
      src.fire(1'b0, 4);
      wait_pops(10 + k);
    end
    src.fire(1'b0, 4);
    repeat (10) @(posedge clk);
    apb(0, OFS_CTRL, 0, 0, 32'h0000_0002);
    // auto trigger with delay and a short exposure raised to the minimum
    src.park(1'b1);
    apb(1, OFS_CFG, 32'h0000_0201, 0, 0);
    apb(1, OFS_EXPO, 32'h0000_0001, 0, 0);
    apb(1, OFS_PERIOD, 32'h0000_012C, 0, 0);
    apb(1, OFS_DELAY, 32'h0000_0002, 0, 0);
    want(3'b100, 0, 0, 0, 0);
    want(3'b100, 1, 0, 0, 0);
    apb(1, OFS_CTRL, 32'h0000_0001, 0, 0);
    t = 0;
    while (show !== 1'b1 && t < 1000) begin
      @(posedge clk);
      t++;
    end
    check("start_delay", 1, 32'(t >= 250 && t <= 256));
    t = 0;
    while (show === 1'b1 && t < 40000) begin
      @(posedge clk);
      t++;
    end
    check("show_length", 31250, t);
    while (show !== 1'b1 && t < 40000) begin
      @(posedge clk);
      t++;
    end
    check("period", 37500, t);
    apb(1, OFS_CTRL, 32'h0000_0000, 0, 0);
    // zero exposure shows for the whole period; a short period is raised to the minimum
    apb(1, OFS_EXPO, 32'h0000_0000, 0, 0);
    apb(1, OFS_PERIOD, 32'h0000_0064, 0, 0);
    apb(1, OFS_DELAY, 32'h0000_0000, 0, 0);
    want(3'b100, 0, 0, 0, 0);
    want(3'b100, 1, 0, 0, 0);
    apb(1, OFS_CTRL, 32'h0000_0001, 0, 0);
    t = 0;
    while (show !== 1'b1 && t < 1000) begin
      @(posedge clk);
      t++;
    end
    t = 0;
    while (show === 1'b1 && pat.index == 7'h00 && t < 40000) begin
      @(posedge clk);
      t++;
    end
    check("whole_period", 31250, t);
    check("still_shown", 1, {31'h0000_0000, show});
    apb(1, OFS_CTRL, 32'h0000_0000, 0, 0);
    repeat (4) @(posedge clk);
    check("pending", 0, pat_q.size() + bus_q.size());
    conclude();
  end
endmodule // tb_stored_pattern_sequencer
`default_nettype wire

// File: verilog/ssq_sequencer.sv
// stored pattern sequencer with apb registers, trigger logic and light control
//
// Notes on behaviour
// - bit depth is accepted only from one to eight
// - pattern count is one up to ninety-six divided by bit depth
// - normal type shows each stored pattern in order, any bit depth
// - inverted type shows each pattern then its complement, depth one only
// - generator type shows fixed generator patterns instead of stored images
// - auto trigger advances each time the trigger period expires
// - command trigger advances only on a host advance command
// - positive external trigger advances after the input goes high
// - negative external trigger advances after the input goes low
// - colour setting picks the red, green or blue source while showing
// - after a trigger wait the delay in microseconds before showing
// - exposure in microseconds; zero means the whole trigger period
// - trigger period sets spacing of successive pattern starts in microseconds
// - exposure or period below minimum is replaced by the minimum
// - inversion swaps black and white of a one-bit pattern
// - generator sequence holds up to 32 entries, any order, optional inversion
`timescale 1ns/10ps
`default_nettype none
module ssq_sequencer (
  input  wire logic            I_CLK_SYS,
  input  wire logic            I_RST,
  input  wire logic            I_PSEL,
  input  wire logic            I_PENABLE,
  input  wire logic            I_PWRITE,
  input  wire logic [7:0]      I_PADDR,
  input  wire logic [31:0]     I_PWDATA,
  output logic [31:0]          O_PRDATA,
  output logic                 O_PREADY,
  output logic                 O_PSLVERR,
  input  wire logic            I_EXT_TRIG,
  output ssq_pkg::ssq_led_t    O_LED,
  output logic                 O_SHOW,
  output ssq_pkg::ssq_pat_t    O_PAT
);
  import ssq_pkg::*;

  // configuration and control state
  logic [3:0]   depth;
  logic [6:0]   count;
  ssq_type_t    ptype;
  ssq_trig_t    tmode;
  ssq_led_sel_t led_sel;
  logic [23:0]  expo_us;
  logic [23:0]  period_us;
  logic [23:0]  delay_us;
  logic         once;
  logic         cmd_next;
  logic [4:0]   gen_tab [0:31];
  // sequencer state
  ssq_state_t   state;
  ssq_state_t   next_state;
  logic [6:0]   idx;
  logic         phase;
  logic         first;
  logic [7:0]   tick_cnt;
  logic [23:0]  dur_cnt;
  logic [23:0]  per_cnt;
  logic         trig_s1;
  logic         trig_s2;
  logic         trig_d;

  // apb decode
  wire         setup     = I_PSEL & ~I_PENABLE;
  wire         wr_take   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  wire         hit_ctrl  = I_PADDR == OFS_CTRL;
  wire         hit_cfg   = I_PADDR == OFS_CFG;
  wire         hit_expo  = I_PADDR == OFS_EXPO;
  wire         hit_per   = I_PADDR == OFS_PERIOD;
  wire         hit_dly   = I_PADDR == OFS_DELAY;
  wire         hit_stat  = I_PADDR == OFS_STATUS;
  wire         hit_tab   = I_PADDR[7];
  wire         mapped    = hit_ctrl | hit_cfg | hit_expo | hit_per | hit_dly | hit_stat |
                           hit_tab;
  wire [4:0]   tab_sel   = I_PADDR[6:2];
  wire [1:0]   lo_bits   = I_PADDR[1:0];

  // checks on a configuration write before it is taken
  wire [3:0]   w_depth   = I_PWDATA[CFG_DEPTH_LSB +: 4];
  wire [6:0]   w_count   = I_PWDATA[CFG_COUNT_LSB +: 7];
  wire [1:0]   w_type    = I_PWDATA[CFG_TYPE_LSB +: 2];
  wire [1:0]   w_led     = I_PWDATA[CFG_LED_LSB +: 2];
  wire [10:0]  w_planes  = 11'(w_count * w_depth);
  wire         ok_depth  = (w_depth >= DEPTH_MIN) && (w_depth <= DEPTH_MAX);
  wire         ok_count  = (w_count != 7'h00) && (w_planes <= BIT_PLANES);
  wire         ok_type   = (w_type == TYP_NORMAL) ||
                           ((w_type == TYP_INVERT) && (w_depth == 4'h1)) ||
                           ((w_type == TYP_GEN) && ({4'h0, w_count} <= {4'h0, GEN_ENTRIES})
                            && (w_depth == 4'h1));
  wire         ok_led    = w_led != 2'b11;
  wire         cfg_ok    = ok_depth & ok_count & ok_type & ok_led;
  wire         bad_wr    = I_PWRITE & (hit_stat | (hit_cfg & ~cfg_ok));
  wire         cfg_wr    = wr_take & hit_cfg & cfg_ok;
  wire         ctrl_wr   = wr_take & hit_ctrl & ~(|lo_bits);
  wire         start_wr  = ctrl_wr & I_PWDATA[CTRL_RUN] & (state == ST_IDLE);
  wire         stop_wr   = ctrl_wr & ~I_PWDATA[CTRL_RUN];
  // minimum substitution and zero exposure meaning whole period
  wire [23:0]  eff_per   = (period_us < MIN_PERIOD) ? MIN_PERIOD : period_us;
  wire [23:0]  eff_expo  = (expo_us == 24'h00_0000) ? eff_per :
                           ((expo_us < MIN_EXPO) ? MIN_EXPO : expo_us);
  // read mux
  wire [31:0]  status    = {21'h00_0000, phase, state, idx};
  wire [31:0]  cfg_rd    = {6'h00, led_sel, 2'h0, tmode, 2'h0, ptype, 1'b0, count, 4'h0,
                            depth};
  wire [31:0]  rd_mux    = hit_ctrl ? {30'h0000_0000, once, state != ST_IDLE} :
                           hit_cfg  ? cfg_rd :
                           hit_expo ? {8'h00, expo_us} :
                           hit_per  ? {8'h00, period_us} :
                           hit_dly  ? {8'h00, delay_us} :
                           hit_stat ? status :
                           hit_tab  ? {27'h000_0000, gen_tab[tab_sel]} : 32'h0000_0000;

  // apb answers in the first access cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
    end else if (setup) begin
      O_PREADY  <= 1'b1;
      O_PSLVERR <= ~mapped | bad_wr | (|lo_bits); // non-word addresses refused both ways
      O_PRDATA  <= (I_PWRITE | ~mapped | (|lo_bits)) ? 32'h0000_0000 : rd_mux;
    end else begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
  end

  // register writes; illegal configurations are refused whole
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      depth     <= RST_DEPTH;
      count     <= RST_COUNT;
      ptype     <= TYP_NORMAL;
      tmode     <= TRG_AUTO;
      led_sel   <= LED_RED;
      expo_us   <= RST_EXPO;
      period_us <= RST_PERIOD;
      delay_us  <= RST_DELAY;
      once      <= 1'b0;
    end else if (wr_take && !(|lo_bits)) begin
      if (cfg_wr) begin
        depth   <= w_depth;
        count   <= w_count;
        ptype   <= ssq_type_t'(w_type);
        tmode   <= ssq_trig_t'(I_PWDATA[CFG_TRIG_LSB +: 2]);
        led_sel <= ssq_led_sel_t'(w_led);
      end
      if (hit_expo) expo_us <= I_PWDATA[23:0];
      if (hit_per) period_us <= I_PWDATA[23:0];
      if (hit_dly) delay_us <= I_PWDATA[23:0];
      if (hit_ctrl) once <= I_PWDATA[CTRL_ONCE];
    end
  end

  // generator table, 32 entries of number and inversion
  always_ff @(posedge I_CLK_SYS) begin
    if (wr_take && hit_tab && !(|lo_bits)) begin
      gen_tab[tab_sel] <= I_PWDATA[4:0];
    end
  end
  // host advance command, one cycle pulse
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) cmd_next <= 1'b0;
    else cmd_next <= ctrl_wr & I_PWDATA[CTRL_NEXT] & I_PWDATA[CTRL_RUN];
  end
  // external trigger synchroniser and edge memory
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d  <= 1'b0;
    end else begin
      trig_s1 <= I_EXT_TRIG;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
    end
  end

  // trigger selection
  wire running   = (state != ST_IDLE);
  wire us_tick   = (tick_cnt == US_CYCLES - 8'd1);
  wire ext_rise  = trig_s2 & ~trig_d;
  wire ext_fall  = ~trig_s2 & trig_d;
  wire auto_due  = first | (us_tick && (per_cnt + 24'd1 >= eff_per));
  wire trig_evt  = (tmode == TRG_AUTO)    ? auto_due :
                   (tmode == TRG_CMD)     ? cmd_next :
                   (tmode == TRG_EXT_POS) ? ext_rise :
                                            ext_fall;
  wire trig_take = running && (state != ST_DELAY) && trig_evt && !stop_wr;
  // position step: inverse phase first, then index with wrap
  wire last_idx  = (idx == count - 7'd1);
  wire need_inv  = (ptype == TYP_INVERT) && !phase;
  wire wrap      = !first && !need_inv && last_idx;
  wire finish    = trig_take && wrap && once;
  wire dly_done  = us_tick && (dur_cnt + 24'd1 >= delay_us);
  wire exp_done  = us_tick && (dur_cnt + 24'd1 >= eff_expo);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (start_wr) next_state = ST_WAIT;
      ST_WAIT,
      ST_SHOW,
      ST_DARK:  begin
        if (trig_take) next_state = (delay_us == 24'h00_0000) ? ST_SHOW : ST_DELAY;
        else if (state == ST_SHOW && exp_done) next_state = ST_DARK;
      end
      ST_DELAY: if (dly_done) next_state = ST_SHOW;
      default:  next_state = ST_IDLE;
    endcase
    if (stop_wr || finish) next_state = ST_IDLE;
  end

  // state, microsecond base and counters
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state    <= ST_IDLE;
      tick_cnt <= 8'h00;
      dur_cnt  <= 24'h00_0000;
      per_cnt  <= 24'h00_0000;
    end else begin
      state    <= next_state;
      tick_cnt <= (trig_take || us_tick || !running) ? 8'h00 : tick_cnt + 8'h01;
      dur_cnt  <= (next_state != state || trig_take) ? 24'h00_0000 :
                  (us_tick ? dur_cnt + 24'h00_0001 : dur_cnt);
      per_cnt  <= trig_take ? 24'h00_0000 : (us_tick ? per_cnt + 24'h00_0001 : per_cnt);
    end
  end

  // sequence position
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      idx   <= 7'h00;
      phase <= 1'b0;
      first <= 1'b0;
    end else if (start_wr) begin
      idx   <= 7'h00;
      phase <= 1'b0;
      first <= 1'b1;
    end else if (trig_take) begin
      first <= 1'b0;
      if (!first) begin
        if (need_inv) phase <= 1'b1;
        else begin
          phase <= 1'b0;
          idx   <= wrap ? 7'h00 : idx + 7'h01;
        end
      end
    end
  end

  // outputs toward light source and display path
  wire       showing = (state == ST_SHOW);
  wire [4:0] gen_ent = gen_tab[idx[4:0]];
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_SHOW <= 1'b0;
      O_LED  <= '0;
      O_PAT  <= '0;
    end else begin
      O_SHOW       <= showing;
      O_LED.red    <= showing && (led_sel == LED_RED);
      O_LED.green  <= showing && (led_sel == LED_GREEN);
      O_LED.blue   <= showing && (led_sel == LED_BLUE);
      O_PAT.index  <= idx;
      O_PAT.gen_en <= (ptype == TYP_GEN);
      O_PAT.gen_num <= gen_ent[GEN_NUM_LSB +: 4];
      O_PAT.invert <= (ptype == TYP_GEN) ? gen_ent[GEN_INV_BIT] : phase;
    end
  end

  // checks on configuration legality
  property p_depth_range;
    @(posedge I_CLK_SYS) disable iff (I_RST) (depth >= DEPTH_MIN) && (depth <= DEPTH_MAX);
  endproperty
  a_depth_range: assert property (p_depth_range) else $error("depth out of range");
  property p_count_range;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (count != 7'h00) && (11'(count * depth) <= BIT_PLANES);
  endproperty
  a_count_range: assert property (p_count_range) else $error("count out of range");
  property p_inv_depth;
    @(posedge I_CLK_SYS) disable iff (I_RST) (ptype == TYP_INVERT) |-> (depth == 4'h1);
  endproperty
  a_inv_depth: assert property (p_inv_depth) else $error("inverse type with depth");
  // checks on triggering and timing
  property p_cmd_only;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (tmode == TRG_CMD && trig_take) |-> $past(ctrl_wr);
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("advance without command");
  property p_ext_pos;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (tmode == TRG_EXT_POS && trig_take) |-> (trig_s2 && !trig_d);
  endproperty
  a_ext_pos: assert property (p_ext_pos) else $error("positive trigger bad edge");
  property p_ext_neg;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (tmode == TRG_EXT_NEG && trig_take) |-> (!trig_s2 && trig_d);
  endproperty
  a_ext_neg: assert property (p_ext_neg) else $error("negative trigger bad edge");
  property p_no_delay;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (trig_take && delay_us == 24'h00_0000 && !finish) |=> (state == ST_SHOW) ##1 O_SHOW;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("zero delay not shown");
  property p_led_sel;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_SHOW |-> (O_LED == {$past(led_sel) == LED_RED, $past(led_sel) == LED_GREEN,
                            $past(led_sel) == LED_BLUE});
  endproperty
  a_led_sel: assert property (p_led_sel) else $error("wrong light source");
  property p_min_sub;
    @(posedge I_CLK_SYS) disable iff (I_RST) (eff_per >= MIN_PERIOD) && (eff_expo >= MIN_EXPO);
  endproperty
  a_min_sub: assert property (p_min_sub) else $error("minimum not substituted");
  property p_wrap;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (trig_take && wrap && !once && !stop_wr) |=> (idx == 7'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("index did not wrap");
  property p_inv_pair;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (trig_take && need_inv && !first) |=> (phase && idx == $past(idx));
  endproperty
  a_inv_pair: assert property (p_inv_pair) else $error("complement not next");
  // main scenarios
  c_auto_run: cover property (@(posedge I_CLK_SYS) tmode == TRG_AUTO && trig_take && !first);
  c_wrap:     cover property (@(posedge I_CLK_SYS) trig_take && wrap);
  c_delay:    cover property (@(posedge I_CLK_SYS) state == ST_DELAY ##1 state == ST_SHOW);
  c_ext_neg:  cover property (@(posedge I_CLK_SYS) tmode == TRG_EXT_NEG && trig_take);
endmodule // ssq_sequencer
`default_nettype wire
